/* bclk_cfg.svh */
// Purpose: Constants of the bus-phase clock and reset pin block.
// Assumes: One clock, the oscillator input, at 25 MHz.
// Notes: Counts are in oscillator cycles or in bus-phase cycles as named.
`ifndef BCLK_CFG_SVH
`define BCLK_CFG_SVH

`define BCLK_DIV_RATIO 4
`define BCLK_PHASE_W 2
`define BCLK_ACCESS_PHASE_FIRST 2'h2
`define BCLK_LAST_PHASE 2'h3
`define BCLK_SENSE_E_CYCLES 2
`define BCLK_HOLD_E_CYCLES_DEF 4
`define BCLK_CNT_W 8
`define BCLK_CLK_PERIOD_NS 40

`endif

/* bclk_pkg.sv */
// Purpose: Types of the bus-phase clock and reset pin block.
// Assumes: Constants come from bclk_cfg.svh.
// Notes: Mode codes follow the two mode-select inputs as {select_1, select_0}.
package bclk_pkg;

    typedef enum logic [1:0] {
        BCLK_MODE_BOOTSTRAP = 2'h0,
        BCLK_MODE_SINGLE_CHIP = 2'h1,
        BCLK_MODE_TEST = 2'h2,
        BCLK_MODE_EXPANDED = 2'h3
    } bclk_mode_e;

    typedef enum logic [1:0] {
        BCLK_ST_RUN,
        BCLK_ST_EXT_RESET,
        BCLK_ST_DRIVE,
        BCLK_ST_SENSE
    } bclk_state_e;

    typedef struct packed {
        bclk_state_e state;
        logic [1:0] phase;
        logic [7:0] cnt;
        logic e_clk;
        logic reset_oe;
        logic sys_reset;
        logic cause_internal;
        logic cause_valid;
        bclk_mode_e mode;
        logic clk_out_disable;
        logic [1:0] rst_sync;
        logic [1:0] msel0_sync;
        logic [1:0] msel1_sync;
        logic [1:0] dis_sync;
    } bclk_state_s;

endpackage

/* bclk_top.sv */
// Purpose: Bus-phase clock generator, clock output gating and reset pin logic.
// Assumes: clock_i is the oscillator input; failure and stop inputs are on clock_i.
// Notes: The reset pin is open drain; the testbench resolves the wire level.
`timescale 1ns/1ps
`include "bclk_cfg.svh"

module bclk_top
    import bclk_pkg::*;
#(
    parameter int HOLD_E_CYCLES = `BCLK_HOLD_E_CYCLES_DEF,
    parameter bit ALWAYS_ON_VARIANT = 1'b0
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic reset_pin_i,
    output logic reset_pin_o,
    output logic reset_pin_oe_o,
    input wire logic watchdog_timer_fail_i,
    input wire logic clock_monitor_fail_i,
    input wire logic stop_mode_i,
    input wire logic mode_select_0_i,
    input wire logic mode_select_1_i,
    input wire logic clk_out_disable_i,
    output logic e_clk_o,
    output logic sys_reset_o,
    output logic cause_internal_o,
    output logic cause_valid_o,
    output bclk_mode_e mode_o
);

    localparam logic [7:0] HOLD_LAST = 8'(HOLD_E_CYCLES - 1);
    localparam logic [7:0] SENSE_LAST = 8'(`BCLK_SENSE_E_CYCLES - 1);

    // The hold counter is eight bits wide, so longer holds cannot be counted.
    if (HOLD_E_CYCLES < 1 || HOLD_E_CYCLES > 256) begin : g_bad_hold
        $error("HOLD_E_CYCLES must lie in 1..256");
    end

    bclk_state_s s_q;
    bclk_state_s s_d;
    logic pin_high;
    logic halt;
    logic e_tick;
    logic failure;
    logic single_chip;
    logic out_enable;

    always_comb begin
        s_d = s_q;
        pin_high = s_q.rst_sync[1];
        failure = watchdog_timer_fail_i | clock_monitor_fail_i;
        // Stop never freezes the reset sequence, or a failure could never be reported.
        halt = stop_mode_i & ~s_q.sys_reset;
        e_tick = ~halt && s_q.phase == `BCLK_LAST_PHASE;
        single_chip = s_q.mode == BCLK_MODE_SINGLE_CHIP || s_q.mode == BCLK_MODE_BOOTSTRAP;

        s_d.rst_sync = {s_q.rst_sync[0], reset_pin_i};
        s_d.msel0_sync = {s_q.msel0_sync[0], mode_select_0_i};
        s_d.msel1_sync = {s_q.msel1_sync[0], mode_select_1_i};
        s_d.dis_sync = {s_q.dis_sync[0], clk_out_disable_i};

        if (!halt) begin
            s_d.phase = s_q.phase + 2'h1;
        end
        s_d.clk_out_disable = s_q.sys_reset ? 1'b0 : s_q.dis_sync[1];
        out_enable = ALWAYS_ON_VARIANT | ~(single_chip & s_d.clk_out_disable);
        // High half of the bus cycle is the data access window.
        s_d.e_clk = ~halt & out_enable & (s_d.phase >= `BCLK_ACCESS_PHASE_FIRST);

        if (s_q.sys_reset) begin
            s_d.mode = bclk_mode_e'({s_q.msel1_sync[1], s_q.msel0_sync[1]});
        end

        case (s_q.state)
            BCLK_ST_RUN: begin
                if (failure) begin
                    s_d.state = BCLK_ST_DRIVE;
                    s_d.reset_oe = 1'b1;
                    s_d.sys_reset = 1'b1;
                    s_d.cause_valid = 1'b0;
                    s_d.cnt = 8'h00;
                end else if (!pin_high) begin
                    s_d.state = BCLK_ST_EXT_RESET;
                    s_d.sys_reset = 1'b1;
                    s_d.cause_valid = 1'b0;
                end
            end
            BCLK_ST_EXT_RESET: begin
                if (pin_high) begin
                    s_d.state = BCLK_ST_RUN;
                    s_d.sys_reset = 1'b0;
                    s_d.cause_internal = 1'b0;
                    s_d.cause_valid = 1'b1;
                end
            end
            BCLK_ST_DRIVE: begin
                if (e_tick) begin
                    if (s_q.cnt == HOLD_LAST) begin
                        s_d.state = BCLK_ST_SENSE;
                        s_d.reset_oe = 1'b0;
                        s_d.cnt = 8'h00;
                    end else begin
                        s_d.cnt = s_q.cnt + 8'h01;
                    end
                end
            end
            BCLK_ST_SENSE: begin
                if (pin_high) begin
                    s_d.state = BCLK_ST_RUN;
                    s_d.sys_reset = 1'b0;
                    s_d.cause_internal = 1'b1;
                    s_d.cause_valid = 1'b1;
                end else if (e_tick) begin
                    if (s_q.cnt == SENSE_LAST) begin
                        // Someone outside still holds the pin: treat it as external.
                        s_d.state = BCLK_ST_EXT_RESET;
                    end else begin
                        s_d.cnt = s_q.cnt + 8'h01;
                    end
                end
            end
            default: begin
                s_d.state = BCLK_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q.state <= BCLK_ST_EXT_RESET;
            s_q.phase <= 2'h0;
            s_q.cnt <= 8'h00;
            s_q.e_clk <= 1'b0;
            s_q.reset_oe <= 1'b0;
            s_q.sys_reset <= 1'b1;
            s_q.cause_internal <= 1'b0;
            s_q.cause_valid <= 1'b0;
            s_q.mode <= BCLK_MODE_BOOTSTRAP;
            s_q.clk_out_disable <= 1'b0;
            s_q.rst_sync <= 2'h0;
            s_q.msel0_sync <= 2'h0;
            s_q.msel1_sync <= 2'h0;
            s_q.dis_sync <= 2'h0;
        end else begin
            s_q <= s_d;
        end
    end

    assign reset_pin_o = 1'b0;
    assign reset_pin_oe_o = s_q.reset_oe;
    assign e_clk_o = s_q.e_clk;
    assign sys_reset_o = s_q.sys_reset;
    assign cause_internal_o = s_q.cause_internal;
    assign cause_valid_o = s_q.cause_valid;
    assign mode_o = s_q.mode;

    property p_div_four;
        @(posedge clock_i) disable iff (!rst_n_i)
        ($rose(e_clk_o) && !stop_mode_i && !sys_reset_o)[*1] ##1 (!stop_mode_i)[*3]
            |-> ##1 $rose(e_clk_o) || !e_clk_o || sys_reset_o;
    endproperty
    a_div_four: assert property (p_div_four) else $error("bus clock period wrong");

    property p_e_high_phase;
        @(posedge clock_i) disable iff (!rst_n_i)
        e_clk_o |-> s_q.phase >= `BCLK_ACCESS_PHASE_FIRST;
    endproperty
    a_e_high_phase: assert property (p_e_high_phase) else $error("clock high in low half");

    property p_stop_halts;
        @(posedge clock_i) disable iff (!rst_n_i)
        (stop_mode_i && !sys_reset_o) ##1 (stop_mode_i && !sys_reset_o) |-> !e_clk_o;
    endproperty
    a_stop_halts: assert property (p_stop_halts) else $error("clock runs in stop");

    property p_disable_gates;
        @(posedge clock_i) disable iff (!rst_n_i)
        (!ALWAYS_ON_VARIANT && s_q.clk_out_disable &&
            (mode_o == BCLK_MODE_SINGLE_CHIP || mode_o == BCLK_MODE_BOOTSTRAP)) ##1
            s_q.clk_out_disable |-> !e_clk_o;
    endproperty
    a_disable_gates: assert property (p_disable_gates) else $error("disabled clock seen");

    property p_disable_cleared;
        @(posedge clock_i) disable iff (!rst_n_i)
        sys_reset_o |=> !s_q.clk_out_disable;
    endproperty
    a_disable_cleared: assert property (p_disable_cleared) else $error("disable kept in reset");

    property p_fail_drives;
        @(posedge clock_i) disable iff (!rst_n_i)
        (s_q.state == BCLK_ST_RUN && (watchdog_timer_fail_i || clock_monitor_fail_i))
            |=> reset_pin_oe_o && !reset_pin_o && sys_reset_o;
    endproperty
    a_fail_drives: assert property (p_fail_drives) else $error("failure not driven");

    property p_ext_resets;
        @(posedge clock_i) disable iff (!rst_n_i)
        (s_q.state == BCLK_ST_RUN && !s_q.rst_sync[1] && !watchdog_timer_fail_i &&
            !clock_monitor_fail_i) |=> sys_reset_o && !cause_valid_o;
    endproperty
    a_ext_resets: assert property (p_ext_resets) else $error("external reset missed");

    property p_quick_rise_internal;
        @(posedge clock_i) disable iff (!rst_n_i)
        (s_q.state == BCLK_ST_SENSE && s_q.rst_sync[1])
            |=> cause_valid_o && cause_internal_o && !sys_reset_o;
    endproperty
    a_quick_rise_internal: assert property (p_quick_rise_internal) else $error("cause wrong");

    property p_hold_release;
        @(posedge clock_i) disable iff (!rst_n_i)
        $fell(reset_pin_oe_o) |-> s_q.state == BCLK_ST_SENSE && $past(s_q.cnt) == HOLD_LAST;
    endproperty
    a_hold_release: assert property (p_hold_release) else $error("hold length wrong");

    property p_mode_frozen;
        @(posedge clock_i) disable iff (!rst_n_i)
        !sys_reset_o ##1 !sys_reset_o |-> $stable(mode_o);
    endproperty
    a_mode_frozen: assert property (p_mode_frozen) else $error("mode changed in run");

endmodule

/* bclk_rst_ext.sv */
// Purpose: External reset circuit on the open-drain reset pin, with pull-up.
// Assumes: The device only ever pulls the pin low through its enable.
// Notes: A slow rise keeps the pin low for a while after the device lets go.
`timescale 1ns/1ps
module bclk_rst_ext (
    input wire logic clock_i,
    input wire logic dev_oe_i,
    input wire logic hold_low_i,
    input wire logic slow_i,
    output logic pin_o
);
    logic [3:0] slow_q = 4'h0;
    logic oe_q = 1'b0;
    // Models a loaded line whose rise takes longer than the internal-cause window.
    always @(posedge clock_i) begin
        oe_q <= dev_oe_i;
        if (oe_q && !dev_oe_i && slow_i) begin
            slow_q <= 4'hc;
        end else if (slow_q != 4'h0) begin
            slow_q <= slow_q - 4'h1;
        end
    end
    // The countdown only starts one edge after the device lets go, so the line is held low
    // in that first cycle too; otherwise a one-cycle high blip would read as a quick rise.
    assign pin_o = !(dev_oe_i || hold_low_i || slow_q != 4'h0 || (oe_q && slow_i));
endmodule

/* bus_clock_and_reset_pin_logic_tb_top.sv */
// Purpose: Self-checking bench of the bus-phase clock and reset pin block.
// Assumes: Hold count of 2 ticks; a second instance is the always-on variant.
// Notes: Outputs are sampled on the falling edge, inputs change on the rising.
`timescale 1ns/1ps
module bus_clock_and_reset_pin_logic_tb_top;
    import bclk_pkg::*;
    logic clock_i, rst_n_i, wdog, cmon, stop, ms0, ms1, dis, hold_low, slow;
    logic pin, pin_o, oe, e_clk, sys_reset, cause_int, cause_valid, oe2, e2;
    bclk_mode_e mode;
    int n_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    bclk_rst_ext bclk_rst_ext_inst (.clock_i(clock_i), .dev_oe_i(oe), .hold_low_i(hold_low),
        .slow_i(slow), .pin_o(pin));
    bclk_top #(.HOLD_E_CYCLES(2)) bclk_top_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .reset_pin_i(pin), .reset_pin_o(pin_o), .reset_pin_oe_o(oe),
        .watchdog_timer_fail_i(wdog), .clock_monitor_fail_i(cmon), .stop_mode_i(stop),
        .mode_select_0_i(ms0), .mode_select_1_i(ms1), .clk_out_disable_i(dis),
        .e_clk_o(e_clk), .sys_reset_o(sys_reset), .cause_internal_o(cause_int),
        .cause_valid_o(cause_valid), .mode_o(mode));
    bclk_top #(.HOLD_E_CYCLES(2), .ALWAYS_ON_VARIANT(1'b1)) bclk_top_var_inst (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .reset_pin_i(!oe2), .reset_pin_o(),
        .reset_pin_oe_o(oe2), .watchdog_timer_fail_i(wdog), .clock_monitor_fail_i(cmon),
        .stop_mode_i(stop), .mode_select_0_i(ms0), .mode_select_1_i(ms1),
        .clk_out_disable_i(dis), .e_clk_o(e2), .sys_reset_o(), .cause_internal_o(),
        .cause_valid_o(), .mode_o());
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_errors++;
            print_verdict();
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic count_e(input int n, output logic [7:0] hi, output logic [7:0] hi2,
        output logic [7:0] rises);
        logic prev;
        hi = 8'h0;
        hi2 = 8'h0;
        rises = 8'h0;
        prev = e_clk;
        repeat (n) begin
            @(negedge clock_i);
            hi = hi + e_clk;
            hi2 = hi2 + e2;
            rises = rises + (e_clk && !prev);
            prev = e_clk;
        end
    endtask
    task automatic wait_run();
        int k;
        k = 0;
        @(negedge clock_i);
        while (sys_reset !== 1'b0 && k < 60) begin
            @(negedge clock_i);
            k++;
        end
    endtask
    task automatic t_eclk_stop();
        logic [7:0] hi, hi2, r;
        count_e(16, hi, hi2, r);
        chk("e_clk high count", 8'h8, hi);
        chk("e_clk rises", 8'h4, r);
        @(posedge clock_i) stop <= 1'b1;
        repeat (3) @(negedge clock_i);
        count_e(16, hi, hi2, r);
        chk("e_clk in stop", 8'h0, hi);
        chk("variant e_clk in stop", 8'h0, hi2);
        @(posedge clock_i) stop <= 1'b0;
    endtask
    task automatic t_ext_reset(input logic [1:0] m);
        logic [7:0] hi, hi2, r;
        @(posedge clock_i);
        ms0 <= m[0];
        ms1 <= m[1];
        hold_low <= 1'b1;
        repeat (4) @(negedge clock_i);
        count_e(8, hi, hi2, r);
        chk("e_clk during reset", 8'h4, hi);
        chk("sys_reset held", 8'h1, sys_reset);
        chk("cause_valid cleared", 8'h0, cause_valid);
        @(posedge clock_i) hold_low <= 1'b0;
        wait_run();
        chk("mode latched", {6'h0, m}, mode);
        chk("cause external", 8'h0, cause_int);
        chk("cause valid", 8'h1, cause_valid);
    endtask
    task automatic t_fail(input bit use_wdog, input bit slow_rise);
        int k;
        @(posedge clock_i);
        slow <= slow_rise;
        wdog <= use_wdog;
        cmon <= !use_wdog;
        @(posedge clock_i);
        wdog <= 1'b0;
        cmon <= 1'b0;
        @(negedge clock_i);
        chk("pin pulled low", 8'h1, oe);
        chk("pin data low", 8'h0, pin_o);
        chk("sys_reset on fail", 8'h1, sys_reset);
        k = 1;
        while (oe !== 1'b0 && k < 40) begin
            @(negedge clock_i);
            k++;
        end
        chk("hold in range", 8'h1, k >= 5 && k <= 9);
        wait_run();
        chk("cause kind", {7'h0, !slow_rise}, cause_int);
        chk("cause valid", 8'h1, cause_valid);
    endtask
    task automatic t_disable();
        logic [7:0] hi, hi2, r;
        t_ext_reset(2'h1);
        @(posedge clock_i) dis <= 1'b1;
        repeat (4) @(negedge clock_i);
        count_e(16, hi, hi2, r);
        chk("disabled in single chip", 8'h0, hi);
        chk("variant ignores disable", 8'h8, hi2);
        t_ext_reset(2'h3);
        count_e(16, hi, hi2, r);
        chk("disable ignored expanded", 8'h8, hi);
        @(posedge clock_i) dis <= 1'b0;
    endtask
    initial begin
        {rst_n_i, wdog, cmon, stop, ms0, ms1, dis, hold_low, slow} = 9'h0;
        repeat (5) @(posedge clock_i);
        rst_n_i <= 1'b1;
        wait_run();
        t_eclk_stop();
        for (int m = 0; m < 4; m++) begin
            t_ext_reset(m[1:0]);
        end
        t_fail(1'b1, 1'b0);
        t_fail(1'b0, 1'b1);
        t_disable();
        print_verdict();
    end
endmodule
